// file: common/pirc_pkg.sv
// Constants, types and strap decode for the transceiver init, reset and power control block
package pirc_pkg;

    // Management register numbers
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_ADV  = 5'h04;

    // Control register fields
    localparam int CTRL_RST  = 15;
    localparam int CTRL_SPD  = 13;
    localparam int CTRL_AN   = 12;
    localparam int CTRL_PD   = 11;
    localparam int CTRL_RAN  = 9;
    localparam int CTRL_DUP  = 8;
    localparam logic [15:0] CTRL_WMASK = 16'hB900;

    // Advertisement register fields
    localparam int ADV_LO = 5;
    localparam int ADV_HI = 8;
    localparam logic [15:0] ADV_RST = 16'h0001;

    // Management frame
    localparam logic [5:0] PRE_BITS = 6'h20;
    localparam logic [1:0] OP_RD    = 2'h2;
    localparam logic [1:0] OP_WR    = 2'h1;
    localparam logic [3:0] HDR_LAST = 4'hC;
    localparam logic [3:0] DAT_LAST = 4'hF;

    // Timing
    localparam int CLK_HZ        = 20_000_000;
    localparam int HW_READY_US   = 1000;
    localparam int HW_READY_CYC  = (HW_READY_US * (CLK_HZ / 1_000_000) + 0);
    localparam logic [3:0] SW_RST_CYC = 4'hF;

    typedef struct packed {
        logic       an_en;
        logic       spd100;
        logic       full;
        logic [3:0] adv;
    } pirc_cfg_t;

    typedef enum {MD_IDLE, MD_HDR, MD_TA, MD_DATA} pirc_md_state_t;

    // Strap decode: 0xx forced {speed,duplex}, 1xx auto-negotiation with advertisement set
    function automatic pirc_cfg_t pirc_decode(input logic [2:0] s);
        pirc_cfg_t c;
        c.an_en  = s[2];
        c.spd100 = s[2] | s[1];
        c.full   = s[2] | s[0];
        case (s)
            3'h5:    c.adv = 4'hC;
            3'h6:    c.adv = 4'h3;
            default: c.adv = 4'hF;
        endcase
        return c;
    endfunction

endpackage

// file: dv/pirc_mgmt_master.sv
// Management station model issuing serial register frames
`timescale 1ns/1ps
module pirc_mgmt_master (
    input  wire logic clk_in,
    input  wire logic mdio_in,
    output logic      mdc_out,
    output logic      mdio_out,
    output logic      mdio_en_out
);
    initial begin
        mdc_out     = 1'b0;
        mdio_out    = 1'b1;
        mdio_en_out = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One frame; reads release the line from turnaround on, clock idles low
    task automatic frame(input logic [1:0] op, input logic [4:0] reg_n, input logic [15:0] wdat,
                         output logic [15:0] rdat);
        logic [63:0] bits;
        bits = {32'hFFFF_FFFF, 2'h1, op, 5'h01, reg_n, 2'h2, wdat};
        rdat = 16'h0000;
        for (int i = 63; i >= 0; i--) begin
            @(posedge clk_in);
            mdc_out     <= 1'b0;
            mdio_out    <= bits[i];
            mdio_en_out <= !(op == pirc_pkg::OP_RD && i < 18);
            repeat (4) @(posedge clk_in);
            mdc_out <= 1'b1;
            rdat    = {rdat[14:0], mdio_in};
            repeat (3) @(posedge clk_in);
        end
        @(posedge clk_in);
        mdc_out     <= 1'b0;
        mdio_en_out <= 1'b0;
    endtask
endmodule // pirc_mgmt_master

// file: dv/tb_phy_init_reset_power_control.sv
// Self-checking bench for the init, reset and power control block
`timescale 1ns/1ps
module tb_phy_init_reset_power_control;
    localparam int READY_CYC = 600;
    logic                clk_sys_in, sys_rst_in, hw_pd, mg_dis, link_fail;
    logic [2:0]          straps;
    logic                mdc, m_dat, m_en, mdio_w, d_out, d_oe_n, port_en, clk_en, pull_en, an_st, fc_st;
    pirc_pkg::pirc_cfg_t cfg;
    logic [15:0]         rd;
    int                  err_total, checks, an_n, fc_n, n0, v, junk;

    // Line has a pull-up when nobody drives
    assign mdio_w = !d_oe_n ? d_out : (m_en ? m_dat : 1'b1);

    pirc_init_ctrl #(.HW_READY_CYC(READY_CYC)) dut_u (
        .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .mdc_in(mdc), .mdio_in(mdio_w),
        .mdio_out(d_out), .mdio_oe_n_out(d_oe_n), .hw_powerdown_pin_in(hw_pd),
        .mgmt_disable_pin_in(mg_dis), .led_strap_pins_in(straps), .phy_addr_pin_in(1'b1),
        .link_fail_in(link_fail), .port_enable_out(port_en), .clock_enable_out(clk_en),
        .pull_enable_out(pull_en), .link_cfg_out(cfg), .an_start_out(an_st), .force_start_out(fc_st));

    pirc_mgmt_master m_u (.clk_in(clk_sys_in), .mdio_in(mdio_w), .mdc_out(mdc), .mdio_out(m_dat),
                          .mdio_en_out(m_en));

    initial begin
        clk_sys_in = 1'b0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end

    always @(posedge clk_sys_in) begin
        if (an_st === 1'b1) an_n++;
        if (fc_st === 1'b1) fc_n++;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Expected values from strap code
    function automatic logic [15:0] adv4(input int s);
        return (s == 5) ? 16'h000C : (s == 6) ? 16'h0003 : 16'h000F;
    endfunction
    function automatic logic [15:0] e_ctrl(input int s);
        return 16'((((s >> 2) | (s >> 1)) & 1) << 13 | ((s >> 2) & 1) << 12 | (((s >> 2) | s) & 1) << 8);
    endfunction
    function automatic logic [15:0] e_adv(input int s);
        return 16'h0001 | (adv4(s) << 5);
    endfunction
    function automatic logic [15:0] e_cfg(input int s);
        return 16'((((s >> 2) & 1) << 6) | ((((s >> 2) | (s >> 1)) & 1) << 5) | ((((s >> 2) | s) & 1) << 4)) | adv4(s);
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic rdreg(input logic [4:0] r);
        m_u.frame(pirc_pkg::OP_RD, r, 16'h0000, rd);
    endtask
    task automatic wrreg(input logic [4:0] r, input logic [15:0] d);
        logic [15:0] dummy;
        m_u.frame(pirc_pkg::OP_WR, r, d, dummy);
    endtask
    task automatic hw_reset(input int s);
        @(posedge clk_sys_in);
        straps     <= s[2:0];
        sys_rst_in <= 1'b1;
        repeat (8) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {sys_rst_in, hw_pd, mg_dis, link_fail, straps} = 7'h40;
        {err_total, checks, an_n, fc_n} = 0;
        junk = $urandom(32'h024B);
        hw_reset(0);
        rdreg(pirc_pkg::REG_CTRL);
        chk(rd, 16'hFFFF);
        for (int s = 0; s < 8; s++) begin
            hw_reset(s);
            n0 = an_n;
            repeat (READY_CYC + 4) @(posedge clk_sys_in);
            chk(16'(an_n - n0), 16'((s >> 2) & 1));
            rdreg(pirc_pkg::REG_CTRL);
            chk(rd, e_ctrl(s));
            rdreg(pirc_pkg::REG_ADV);
            chk(rd, e_adv(s));
            chk({9'h000, cfg}, e_cfg(s));
            chk({15'h0000, port_en}, 16'h0001);
        end
        v = $urandom_range(15, 0);
        wrreg(pirc_pkg::REG_ADV, 16'hFE1F | 16'(v << 5));
        rdreg(pirc_pkg::REG_ADV);
        chk(rd, 16'h0001 | 16'(v << 5));
        n0 = fc_n;
        wrreg(pirc_pkg::REG_CTRL, 16'h4100);
        repeat (4) @(posedge clk_sys_in);
        chk(16'(fc_n - n0), 16'h0001);
        chk({9'h000, cfg}, 16'h0010 | 16'(v));
        rdreg(pirc_pkg::REG_CTRL);
        chk(rd, 16'h0100);
        wrreg(pirc_pkg::REG_CTRL, 16'h0900);
        repeat (4) @(posedge clk_sys_in);
        chk({15'h0000, port_en}, 16'h0000);
        rdreg(pirc_pkg::REG_CTRL);
        chk(rd, 16'h0900);
        rdreg(5'h11);
        chk(rd, 16'h0000);
        straps <= 3'h5;
        wrreg(pirc_pkg::REG_CTRL, 16'h8000);
        for (int t = 0; t < 20; t++) begin
            rdreg(pirc_pkg::REG_CTRL);
            if (rd[15] === 1'b0) break;
            if (t == 19) err_total++;
        end
        chk(rd, e_ctrl(7));
        rdreg(pirc_pkg::REG_ADV);
        chk(rd, e_adv(7));
        n0 = an_n + fc_n;
        link_fail <= 1'b1;
        repeat (8) @(posedge clk_sys_in);
        chk(16'(an_n + fc_n - n0), 16'h0001);
        link_fail <= 1'b0;
        mg_dis    <= 1'b1;
        wrreg(pirc_pkg::REG_ADV, 16'h0000);
        rdreg(pirc_pkg::REG_ADV);
        chk(rd, 16'hFFFF);
        mg_dis <= 1'b0;
        rdreg(pirc_pkg::REG_ADV);
        chk(rd, e_adv(7));
        hw_pd <= 1'b1;
        rdreg(pirc_pkg::REG_CTRL);
        chk(rd, 16'hFFFF);
        chk({13'h0000, port_en, clk_en, pull_en}, 16'h0000);
        stop_test();
    end
endmodule // tb_phy_init_reset_power_control

// file: hdl/pirc_init_ctrl.sv
// Init, reset and reduced-power control with management frame slave
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module pirc_init_ctrl #(
    parameter int HW_READY_CYC = pirc_pkg::HW_READY_CYC
) (
    input  wire logic               clk_sys_in,
    input  wire logic               sys_rst_in,
    input  wire logic               mdc_in,
    input  wire logic               mdio_in,
    output logic                    mdio_out,
    output logic                    mdio_oe_n_out,
    input  wire logic               hw_powerdown_pin_in,
    input  wire logic               mgmt_disable_pin_in,
    input  wire logic [2:0]         led_strap_pins_in,
    input  wire logic               phy_addr_pin_in,
    input  wire logic               link_fail_in,
    output logic                    port_enable_out,
    output logic                    clock_enable_out,
    output logic                    pull_enable_out,
    output pirc_pkg::pirc_cfg_t     link_cfg_out,
    output logic                    an_start_out,
    output logic                    force_start_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [8:0] sync1_q;
    logic [8:0] sync2_q;
    logic       mdc_d3_q;
    logic       lf_d3_q;

    always_ff @(posedge clk_sys_in) begin
        sync1_q  <= {phy_addr_pin_in, led_strap_pins_in, link_fail_in, mgmt_disable_pin_in,
                     hw_powerdown_pin_in, mdio_in, mdc_in};
        sync2_q  <= sync1_q;
        mdc_d3_q <= sync2_q[0];
        lf_d3_q  <= sync2_q[4];
    end

    logic       mdc_s;
    logic       mdio_s;
    logic       pd_s;
    logic       mgmt_dis_s;
    logic       lf_s;
    logic [2:0] strap_s;
    logic       addr_s;
    logic       mdc_rise;
    logic       lf_rise;

    assign mdc_s    = sync2_q[0];
    assign mdio_s   = sync2_q[1];
    assign pd_s     = sync2_q[2];
    assign mgmt_dis_s = sync2_q[3];
    assign lf_s     = sync2_q[4];
    assign strap_s  = sync2_q[7:5];
    assign addr_s   = sync2_q[8];
    assign mdc_rise = mdc_s & ~mdc_d3_q;
    assign lf_rise  = lf_s & ~lf_d3_q;

    ////////////////////////////////////////////////////////////////////////////
    // Hardware reset window and strap latch
    logic [31:0] hw_cnt_q;
    logic        hw_ready_q;
    logic [2:0]  strap_lat_q;
    logic        addr_lat_q;

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            hw_cnt_q   <= 32'h00000000;
            hw_ready_q <= 1'b0;
        end else if (!hw_ready_q) begin
            hw_cnt_q   <= hw_cnt_q + 32'h00000001;
            hw_ready_q <= (hw_cnt_q == 32'(HW_READY_CYC - 1));
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            strap_lat_q <= 3'h0;
            addr_lat_q  <= 1'b0;
        end else if (!hw_ready_q) begin
            strap_lat_q <= strap_s;
            addr_lat_q  <= addr_s;
        end
    end

    pirc_pkg::pirc_cfg_t strap_cfg;
    logic [15:0]         strap_ctrl;
    logic [15:0]         strap_adv;

    assign strap_cfg  = pirc_pkg::pirc_decode(strap_lat_q);
    assign strap_ctrl = (16'(strap_cfg.spd100) << pirc_pkg::CTRL_SPD)
                      | (16'(strap_cfg.an_en) << pirc_pkg::CTRL_AN)
                      | (16'(strap_cfg.full) << pirc_pkg::CTRL_DUP);
    assign strap_adv  = pirc_pkg::ADV_RST | (16'(strap_cfg.adv) << pirc_pkg::ADV_LO);

    ////////////////////////////////////////////////////////////////////////////
    // Management frame slave
    logic                     access_ok;
    pirc_pkg::pirc_md_state_t st_q;
    logic [5:0]               ones_q;
    logic [3:0]               cnt_q;
    logic [12:0]              hdr_q;
    logic [15:0]              sh_q;
    logic                     rd_q;
    logic [4:0]               reg_q;
    logic                     drv_q;
    logic                     out_q;
    logic [15:0]              ctrl_q;
    logic [15:0]              adv_q;
    logic [12:0]              hdr_n;
    logic [15:0]              rd_word;
    logic                     wr_go;

    assign access_ok = hw_ready_q & ~pd_s & ~mgmt_dis_s;
    assign hdr_n     = {hdr_q[11:0], mdio_s};
    assign wr_go     = access_ok & mdc_rise & (st_q == pirc_pkg::MD_DATA) & ~rd_q & (cnt_q == pirc_pkg::DAT_LAST);

    always_comb begin
        case (hdr_n[4:0])
            pirc_pkg::REG_CTRL: rd_word = ctrl_q;
            pirc_pkg::REG_ADV:  rd_word = adv_q;
            default:            rd_word = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in || !access_ok) begin
            st_q   <= pirc_pkg::MD_IDLE;
            ones_q <= 6'h00;
            cnt_q  <= 4'h0;
            drv_q  <= 1'b0;
            out_q  <= 1'b1;
            rd_q   <= 1'b0;
        end else if (mdc_rise) begin
            case (st_q)
                pirc_pkg::MD_IDLE: begin
                    cnt_q <= 4'h0;
                    if (mdio_s) begin
                        ones_q <= (ones_q == pirc_pkg::PRE_BITS) ? ones_q : ones_q + 6'h01;
                    end else begin
                        ones_q <= 6'h00;
                        if (ones_q == pirc_pkg::PRE_BITS) begin
                            st_q <= pirc_pkg::MD_HDR;
                        end
                    end
                end
                pirc_pkg::MD_HDR: begin
                    hdr_q <= hdr_n;
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == pirc_pkg::HDR_LAST) begin
                        cnt_q <= 4'h0;
                        reg_q <= hdr_n[4:0];
                        rd_q  <= (hdr_n[11:10] == pirc_pkg::OP_RD);
                        sh_q  <= rd_word;
                        if (hdr_n[12] && hdr_n[9:5] == {4'h0, addr_lat_q}
                            && (hdr_n[11:10] == pirc_pkg::OP_RD || hdr_n[11:10] == pirc_pkg::OP_WR)) begin
                            st_q <= pirc_pkg::MD_TA;
                        end else begin
                            st_q <= pirc_pkg::MD_IDLE;
                        end
                    end
                end
                pirc_pkg::MD_TA: begin
                    cnt_q <= cnt_q + 4'h1;
                    if (rd_q) begin
                        drv_q <= 1'b1;
                        out_q <= (cnt_q == 4'h0) ? 1'b0 : sh_q[15];
                    end
                    if (cnt_q == 4'h1) begin
                        st_q  <= pirc_pkg::MD_DATA;
                        cnt_q <= 4'h0;
                        if (rd_q) begin
                            sh_q <= {sh_q[14:0], mdio_s};
                        end
                    end
                end
                pirc_pkg::MD_DATA: begin
                    cnt_q <= cnt_q + 4'h1;
                    sh_q  <= {sh_q[14:0], mdio_s};
                    out_q <= sh_q[15];
                    if (cnt_q == pirc_pkg::DAT_LAST) begin
                        st_q  <= pirc_pkg::MD_IDLE;
                        drv_q <= 1'b0;
                        out_q <= 1'b1;
                    end
                end
                default: st_q <= pirc_pkg::MD_IDLE;
            endcase
        end
    end

    assign mdio_out      = out_q;
    assign mdio_oe_n_out = ~(drv_q & access_ok);

    ////////////////////////////////////////////////////////////////////////////
    // Control and advertisement registers
    logic [3:0]  sw_cnt_q;
    logic        sw_done;
    logic [15:0] wdata;

    assign sw_done = ctrl_q[pirc_pkg::CTRL_RST] & (sw_cnt_q == pirc_pkg::SW_RST_CYC);
    assign wdata   = {sh_q[14:0], mdio_s};

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in || !ctrl_q[pirc_pkg::CTRL_RST]) begin
            sw_cnt_q <= 4'h0;
        end else begin
            sw_cnt_q <= sw_cnt_q + 4'h1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            ctrl_q <= 16'h0000;
            adv_q  <= pirc_pkg::ADV_RST;
        end else if (!hw_ready_q) begin
            ctrl_q <= strap_ctrl;
            adv_q  <= strap_adv;
        end else if (ctrl_q[pirc_pkg::CTRL_RST]) begin
            if (sw_done) begin
                ctrl_q <= strap_ctrl;
                adv_q  <= strap_adv;
            end
        end else if (wr_go && reg_q == pirc_pkg::REG_CTRL) begin
            ctrl_q <= wdata & pirc_pkg::CTRL_WMASK;
        end else if (wr_go && reg_q == pirc_pkg::REG_ADV) begin
            adv_q[pirc_pkg::ADV_HI:pirc_pkg::ADV_LO] <= wdata[pirc_pkg::ADV_HI:pirc_pkg::ADV_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link bring-up and power control
    logic start;
    logic wr_ctrl;
    logic an_sel;
    logic ready_d_q;
    logic port_en_q;
    logic an_q;
    logic force_q;
    pirc_pkg::pirc_cfg_t cfg_q;

    assign wr_ctrl = wr_go & (reg_q == pirc_pkg::REG_CTRL) & ~ctrl_q[pirc_pkg::CTRL_RST];
    assign start   = (hw_ready_q & ~ready_d_q) | sw_done
                   | (lf_rise & hw_ready_q & ~ctrl_q[pirc_pkg::CTRL_RST])
                   | wr_ctrl;
    // Kind follows the value the control register takes at this edge
    assign an_sel  = sw_done ? strap_ctrl[pirc_pkg::CTRL_AN]
                   : (wr_ctrl ? wdata[pirc_pkg::CTRL_AN] : ctrl_q[pirc_pkg::CTRL_AN]);

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            ready_d_q <= 1'b0;
            port_en_q <= 1'b0;
            an_q      <= 1'b0;
            force_q   <= 1'b0;
            cfg_q     <= '0;
        end else begin
            ready_d_q <= hw_ready_q;
            port_en_q <= hw_ready_q & ~pd_s & ~ctrl_q[pirc_pkg::CTRL_PD]
                       & ~ctrl_q[pirc_pkg::CTRL_RST];
            an_q      <= start & an_sel;
            force_q   <= start & ~an_sel;
            cfg_q     <= '{an_en:  ctrl_q[pirc_pkg::CTRL_AN],
                           spd100: ctrl_q[pirc_pkg::CTRL_SPD],
                           full:   ctrl_q[pirc_pkg::CTRL_DUP],
                           adv:    adv_q[pirc_pkg::ADV_HI:pirc_pkg::ADV_LO]};
        end
    end

    assign port_enable_out  = port_en_q;
    assign clock_enable_out = ~pd_s;
    assign pull_enable_out  = ~pd_s;
    assign an_start_out     = an_q;
    assign force_start_out  = force_q;
    assign link_cfg_out     = cfg_q;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    localparam int SW_CHK = 17;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);

    a_pd_port_off:     assert property (pd_s |=> !port_enable_out)
        else $error("port enabled in hardware power-down");
    a_pd_mdio_free:    assert property (pd_s |-> mdio_oe_n_out ##1 st_q == pirc_pkg::MD_IDLE)
        else $error("management active in hardware power-down");
    a_soft_pd_off:     assert property (ctrl_q[pirc_pkg::CTRL_PD] |=> !port_enable_out)
        else $error("port enabled in soft power-down");
    a_swrst_ends:      assert property ($rose(ctrl_q[pirc_pkg::CTRL_RST])
        |-> ##[1:SW_CHK] !ctrl_q[pirc_pkg::CTRL_RST])
        else $error("software reset bit not cleared");
    a_swrst_restore:   assert property ($fell(ctrl_q[pirc_pkg::CTRL_RST]) && hw_ready_q
        |-> adv_q == strap_adv)
        else $error("advertisement not restored from latch");
    a_hwmode_nowrite:  assert property (mgmt_dis_s && hw_ready_q && !ctrl_q[pirc_pkg::CTRL_RST]
        |=> $stable(adv_q))
        else $error("register changed in hardware control mode");
    a_ready_block:     assert property (!hw_ready_q |-> st_q == pirc_pkg::MD_IDLE && mdio_oe_n_out)
        else $error("management access before ready");
    a_strap_load:      assert property ($rose(hw_ready_q) |-> ctrl_q[pirc_pkg::CTRL_AN] == strap_cfg.an_en)
        else $error("strap not loaded at ready");
    a_start_kind:      assert property (an_start_out |-> !force_start_out ##1 link_cfg_out.an_en)
        else $error("wrong start kind");
    a_link_fail_start: assert property (lf_rise && hw_ready_q && !ctrl_q[pirc_pkg::CTRL_RST]
        |=> an_start_out || force_start_out)
        else $error("no restart on link failure");

    c_sw_reset:  cover property ($fell(ctrl_q[pirc_pkg::CTRL_RST]));
    c_read_data: cover property (st_q == pirc_pkg::MD_DATA && !mdio_oe_n_out);
    c_an_start:  cover property (an_start_out);
    c_forced:    cover property (force_start_out);

endmodule // pirc_init_ctrl
